// file: hw/tcp_pkg.sv
// Constants, field layout and types of the timer counter core.
// Assumes byte-wide registers, one per 32-bit Avalon word.
package tcp_pkg;
  // ***********************************************
  // Bus and register geometry
  // ***********************************************
  localparam int TCP_ADDR_W = 9;
  localparam int TCP_DATA_W = 32;
  localparam int TCP_IDX_W = 7;
  localparam int TCP_IDX_LSB = 2;
  localparam int TCP_REG_W = 8;
  localparam int TCP_CNT_W = 16;
  localparam int TCP_PS_W = 3;
  localparam int TCP_DIV_W = 6;
  localparam int TCP_NCHAN = 2;
  // ***********************************************
  // Register indices (byte address is four times)
  // ***********************************************
  localparam logic [6:0] TCP_IDX_STATUS = 7'h40;
  localparam logic [6:0] TCP_IDX_CNT_HI = 7'h41;
  localparam logic [6:0] TCP_IDX_CNT_LO = 7'h42;
  localparam logic [6:0] TCP_IDX_MOD_HI = 7'h43;
  localparam logic [6:0] TCP_IDX_MOD_LO = 7'h44;
  localparam logic [6:0] TCP_IDX_CHAN_CFG = 7'h4F;
  // ***********************************************
  // Status/control fields
  // ***********************************************
  localparam int TCP_BIT_OVF = 7;
  localparam int TCP_BIT_OVIE = 6;
  localparam int TCP_BIT_HALT = 5;
  localparam int TCP_BIT_CLR = 4;
  localparam int TCP_PS_LSB = 0;
  localparam logic [2:0] TCP_PS_EXT = 3'h7;
  // Channel configuration fields
  localparam int TCP_CFG_CMP_LSB = 0;
  localparam int TCP_CFG_BUF_LSB = 2;
  // ***********************************************
  // Reset values and increment steps
  // ***********************************************
  localparam logic [7:0] TCP_STATUS_RST = 8'h20;
  localparam logic [15:0] TCP_CNT_RST = 16'h0000;
  localparam logic [15:0] TCP_MOD_RST = 16'hFFFF;
  localparam logic [7:0] TCP_CHAN_RST = 8'h00;
  localparam logic [15:0] TCP_CNT_STEP = 16'h0001;
  localparam logic [5:0] TCP_DIV_STEP = 6'h01;
  // Bus handshake states
  typedef enum logic {TCP_BUS_IDLE, TCP_BUS_ACK} tcp_bus_state_t;
endpackage : tcp_pkg

// file: hw/tcp_presc_if.sv
// Link between the counter core and its prescaler.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface tcp_presc_if;
  logic [2:0] select;
  logic clear;
  logic tick;
  modport core (output select, output clear, input tick);
  modport presc (input select, input clear, output tick);
endinterface : tcp_presc_if

// file: hw/tcp_prescaler.sv
// Prescaler: bus clock divider and external count clock edge detector.
// Assumes the external clock obeys the frequency limit of the source.
`timescale 1ns/1ps
module tcp_prescaler
  import tcp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ext_count_clock,
  tcp_presc_if.presc pif
);
  logic [TCP_DIV_W-1:0] div_reg;
  logic [TCP_DIV_W-1:0] div_mask;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic tick_div;
  logic tick_ext;

  // Free-running divider, cleared with the counter
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      div_reg <= '0;
    else if (pif.clear)
      div_reg <= '0;
    else
      div_reg <= div_reg + TCP_DIV_STEP;
  end

  // Two-stage synchroniser, then an edge stage
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= ext_count_clock;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Divide by two to the select code: low bits all ones
  always_comb
  begin
    div_mask = ~TCP_DIV_W'({TCP_DIV_W{1'b1}} << pif.select);
    tick_div = ((div_reg & div_mask) == div_mask);
    tick_ext = sync2_reg & ~sync3_reg;
  end

  // Code seven hands the count over to the pin
  assign pif.tick = pif.clear ? 1'b0 :
    ((pif.select == TCP_PS_EXT) ? tick_ext : tick_div);
endmodule : tcp_prescaler

// file: hw/tcp_core.sv
// Timer counter core: prescaler select, modulo counter, overflow flag,
// and an Avalon-MM slave holding the status/control and count bytes.
// Assumes a single 100 MHz bus clock and synchronous pin inputs.
`timescale 1ns/1ps
module tcp_core
  import tcp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [TCP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [TCP_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [TCP_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_count_clock,
  input wire logic break_active,
  input wire logic break_clear_enable,
  output logic [TCP_CNT_W-1:0] count_value,
  output logic overflow_event,
  output logic overflow_irq,
  output logic [TCP_NCHAN-1:0] capture_inhibit,
  output logic [TCP_NCHAN-1:0] channel_compare_mode,
  output logic [TCP_NCHAN-1:0] channel_buffered
);

  // ***********************************************
  // Declarations
  // ***********************************************
  tcp_bus_state_t bus_state_reg;
  tcp_bus_state_t bus_state_next;
  logic [TCP_DATA_W-1:0] readdata_reg;
  logic [TCP_IDX_W-1:0] reg_idx;
  logic [TCP_REG_W-1:0] rd_byte;
  logic [TCP_REG_W-1:0] wr_byte;
  logic bus_req;
  logic fire_rd;
  logic fire_wr;

  logic [TCP_CNT_W-1:0] cnt_reg;
  logic [TCP_CNT_W-1:0] mod_reg;
  logic [TCP_CNT_W-1:0] cnt_snap_reg;
  logic [TCP_REG_W-1:0] lo_buf_reg;
  logic lo_latched_reg;
  logic mod_inhibit_reg;

  logic ovf_reg;
  logic ovf_armed_reg;
  logic ovie_reg;
  logic halt_reg;
  logic [TCP_PS_W-1:0] ps_reg;
  logic [TCP_REG_W-1:0] chan_cfg_reg;
  logic ovf_event_reg;

  logic advance;
  logic wrap;
  logic ovf_set;
  logic ovf_clear;
  logic cnt_clear;
  logic flags_locked;
  logic status_wr;
  logic status_rd;

  tcp_presc_if pif ();

  // ***********************************************
  // Prescaler
  // ***********************************************
  tcp_prescaler u_prescaler (
    .clock (clock),
    .nrst (nrst),
    .ext_count_clock (ext_count_clock),
    .pif (pif)
  );

  // The counter clear also restarts the divider phase
  assign pif.select = ps_reg;
  assign pif.clear = cnt_clear;

  // ***********************************************
  // Avalon-MM slave handshake
  // ***********************************************
  // Fixed one wait state: the read byte is captured in the first
  // cycle so readdata comes from a flop; side effects wait for the
  // cycle in which the master sees waitrequest low.
  assign bus_req = avs_read | avs_write;
  assign reg_idx = avs_address[TCP_ADDR_W-1:TCP_IDX_LSB];
  assign wr_byte = avs_writedata[TCP_REG_W-1:0];
  assign avs_waitrequest = bus_req & (bus_state_reg != TCP_BUS_ACK);
  assign fire_rd = avs_read & (bus_state_reg == TCP_BUS_ACK);
  assign fire_wr = avs_write & (bus_state_reg == TCP_BUS_ACK)
    & avs_byteenable[0];
  assign avs_readdata = readdata_reg;

  // Next bus state
  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      TCP_BUS_IDLE:
      begin
        if (bus_req)
          bus_state_next = TCP_BUS_ACK;
      end
      TCP_BUS_ACK:
        bus_state_next = TCP_BUS_IDLE;
      default:
        bus_state_next = TCP_BUS_IDLE;
    endcase
  end

  // Bus state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      bus_state_reg <= TCP_BUS_IDLE;
    else
      bus_state_reg <= bus_state_next;
  end

  // Read multiplexer; unmapped registers and reserved status bits read as zero
  always_comb
  begin
    rd_byte = '0;
    case (reg_idx)
      TCP_IDX_STATUS:
      begin
        rd_byte[TCP_BIT_OVF] = ovf_reg;
        rd_byte[TCP_BIT_OVIE] = ovie_reg;
        rd_byte[TCP_BIT_HALT] = halt_reg;
        rd_byte[TCP_BIT_CLR] = 1'b0;
        rd_byte[TCP_PS_LSB +: TCP_PS_W] = ps_reg;
      end
      TCP_IDX_CNT_HI:
        rd_byte = cnt_reg[TCP_CNT_W-1:TCP_REG_W];
      TCP_IDX_CNT_LO:
        rd_byte = lo_latched_reg ? lo_buf_reg :
          cnt_reg[TCP_REG_W-1:0];
      TCP_IDX_MOD_HI:
        rd_byte = mod_reg[TCP_CNT_W-1:TCP_REG_W];
      TCP_IDX_MOD_LO:
        rd_byte = mod_reg[TCP_REG_W-1:0];
      TCP_IDX_CHAN_CFG:
        rd_byte = chan_cfg_reg;
      default:
        rd_byte = '0;
    endcase
  end

  // Read data and counter snapshot, both taken in the wait cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      readdata_reg <= '0;
      cnt_snap_reg <= TCP_CNT_RST;
    end
    else if (avs_read && bus_state_reg == TCP_BUS_IDLE)
    begin
      readdata_reg <= {{(TCP_DATA_W-TCP_REG_W){1'b0}}, rd_byte};
      cnt_snap_reg <= cnt_reg;
    end
  end

  // ***********************************************
  // Control fields of the status/control register
  // ***********************************************
  assign status_wr = fire_wr & (reg_idx == TCP_IDX_STATUS);
  assign status_rd = fire_rd & (reg_idx == TCP_IDX_STATUS);
  assign cnt_clear = status_wr & wr_byte[TCP_BIT_CLR];

  // Control bits stay writable during a break; only flags are guarded
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ovie_reg <= TCP_STATUS_RST[TCP_BIT_OVIE];
      halt_reg <= TCP_STATUS_RST[TCP_BIT_HALT];
      ps_reg <= TCP_STATUS_RST[TCP_PS_LSB +: TCP_PS_W];
    end
    else if (status_wr)
    begin
      ovie_reg <= wr_byte[TCP_BIT_OVIE];
      halt_reg <= wr_byte[TCP_BIT_HALT];
      ps_reg <= wr_byte[TCP_PS_LSB +: TCP_PS_W];
    end
  end

  // ***********************************************
  // Counter
  // ***********************************************
  // A new halt value only acts from the next tick on, so halt and
  // clear in one write leave a zero counter that does not move.
  assign advance = pif.tick & ~halt_reg & ~break_active;
  assign wrap = advance & (cnt_reg == mod_reg);

  // Clear beats wrap beats increment
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= TCP_CNT_RST;
    else if (cnt_clear)
      cnt_reg <= TCP_CNT_RST;
    else if (wrap)
      cnt_reg <= TCP_CNT_RST;
    else if (advance)
      cnt_reg <= cnt_reg + TCP_CNT_STEP;
  end

  // Overflow event pulse for the channel logic, one cycle per wrap
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ovf_event_reg <= 1'b0;
    else
      ovf_event_reg <= wrap;
  end

  assign count_value = cnt_reg;
  assign overflow_event = ovf_event_reg;

  // ***********************************************
  // Coherent 16-bit count read
  // ***********************************************
  // A forgotten low-byte read keeps the buffer latched; software must
  // read the low byte to release it, also inside a break.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      lo_buf_reg <= '0;
      lo_latched_reg <= 1'b0;
    end
    else if (fire_rd && reg_idx == TCP_IDX_CNT_HI)
    begin
      if (!lo_latched_reg)
      begin
        lo_buf_reg <= cnt_snap_reg[TCP_REG_W-1:0];
        lo_latched_reg <= 1'b1;
      end
    end
    else if (fire_rd && reg_idx == TCP_IDX_CNT_LO)
      lo_latched_reg <= 1'b0;
  end

  // ***********************************************
  // Modulo value
  // ***********************************************
  // Bytes land directly; the inhibit hides a half-written limit.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mod_reg <= TCP_MOD_RST;
      mod_inhibit_reg <= 1'b0;
    end
    else if (fire_wr && reg_idx == TCP_IDX_MOD_HI)
    begin
      mod_reg[TCP_CNT_W-1:TCP_REG_W] <= wr_byte;
      mod_inhibit_reg <= 1'b1;
    end
    else if (fire_wr && reg_idx == TCP_IDX_MOD_LO)
    begin
      mod_reg[TCP_REG_W-1:0] <= wr_byte;
      mod_inhibit_reg <= 1'b0;
    end
  end

  // ***********************************************
  // Overflow flag and two-step clear
  // ***********************************************
  // Break with clearing disabled freezes the flag and its arming.
  assign flags_locked = break_active & ~break_clear_enable;
  assign ovf_set = wrap & ~mod_inhibit_reg;
  // Only a 0 in the flag position clears; a 1 is ignored
  assign ovf_clear = status_wr & ~wr_byte[TCP_BIT_OVF]
    & ovf_armed_reg & ~flags_locked;

  // Arming follows a read that saw the flag set
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ovf_armed_reg <= 1'b0;
    else if (ovf_set)
      ovf_armed_reg <= 1'b0;
    else if (status_rd && readdata_reg[TCP_BIT_OVF] && !flags_locked)
      ovf_armed_reg <= 1'b1;
    else if (ovf_clear)
      ovf_armed_reg <= 1'b0;
  end

  // Set wins over clear in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ovf_reg <= TCP_STATUS_RST[TCP_BIT_OVF];
    else if (ovf_set)
      ovf_reg <= 1'b1;
    else if (ovf_clear)
      ovf_reg <= 1'b0;
  end

  // Interrupt held back while the modulo value is half written
  assign overflow_irq = ovf_reg & ovie_reg
    & ~mod_inhibit_reg;

  // ***********************************************
  // Channel configuration and capture gating
  // ***********************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      chan_cfg_reg <= TCP_CHAN_RST;
    else if (fire_wr && reg_idx == TCP_IDX_CHAN_CFG)
      chan_cfg_reg <= wr_byte;
  end

  // Per channel: mode bits out, captures blocked in break, and in halt unless in compare mode
  genvar ch;
  generate
    for (ch = 0; ch < TCP_NCHAN; ch++)
    begin : g_chan
      assign channel_compare_mode[ch] =
        chan_cfg_reg[TCP_CFG_CMP_LSB + ch];
      assign channel_buffered[ch] =
        chan_cfg_reg[TCP_CFG_BUF_LSB + ch];
      assign capture_inhibit[ch] = break_active
        | (halt_reg & ~chan_cfg_reg[TCP_CFG_CMP_LSB + ch]);
    end
  endgenerate

endmodule : tcp_core

// file: tb/tcp_ext_src.sv
// External count clock source that drives the timer clock pin.
// Assumes the bench asks for a burst of rising edges by a start pulse.
`timescale 1ns/1ps
module tcp_ext_src
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] edges,
  output logic ext_count_clock,
  output logic busy
);
  logic [4:0] phase_reg;
  logic [7:0] left_reg;
  // ****************
  // Burst generator
  // ****************
  // 13 cycles high, 13 low: 3.85 MHz keeps under both speed limits
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_reg <= 5'h00;
      left_reg <= 8'h00;
      ext_count_clock <= 1'b0;
    end
    else if (start && left_reg == 8'h00)
    begin
      left_reg <= edges;
      phase_reg <= 5'h00;
    end
    else if (left_reg != 8'h00)
    begin
      phase_reg <= (phase_reg == 5'h19) ? 5'h00 : phase_reg + 5'h01;
      if (phase_reg == 5'h00)
        ext_count_clock <= 1'b1;
      if (phase_reg == 5'h0D)
        ext_count_clock <= 1'b0;
      if (phase_reg == 5'h19)
        left_reg <= left_reg - 8'h01;
    end
  end
  // Pin stands low between bursts, so no stray edge reaches the core
  assign busy = left_reg != 8'h00;
endmodule : tcp_ext_src

// file: tb/tcp_core_sva.sv
// Checker of the timer counter core, watching its top ports only.
// Assumes one clock domain and the one-wait-state register bus.
`timescale 1ns/1ps
module tcp_core_sva
  import tcp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [TCP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [TCP_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic break_active,
  input wire logic [TCP_CNT_W-1:0] count_value,
  input wire logic overflow_event,
  input wire logic [TCP_NCHAN-1:0] capture_inhibit,
  input wire logic [TCP_NCHAN-1:0] channel_compare_mode
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic req;
  logic rd_ack;
  // Bus views shared by several properties
  assign req = avs_read | avs_write;
  assign rd_ack = avs_read & ~avs_waitrequest;
  sequence s_new_req;
    req && !$past(req);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // A clear write is excluded: it wins over the wrap detection
  sequence s_wrap;
    $past(count_value) != 16'h0000 && count_value == 16'h0000
      && !$past(avs_write);
  endsequence
  AST_WAIT_ONE: assert property (s_new_req |-> s_one_wait)
    else $error("bus answer not after exactly one wait cycle");
  AST_WRAP_EVT: assert property (s_wrap |-> ##[0:1] overflow_event)
    else $error("wrap to zero without overflow event");
  AST_COUNT_STEP: assert property ($changed(count_value) |->
    count_value == $past(count_value) + TCP_CNT_STEP || count_value == '0)
    else $error("counter moved other than by one or to zero");
  AST_BRK_FREEZE: assert property (break_active && !avs_write
    |=> $stable(count_value))
    else $error("counter moved during break");
  AST_CAP_BRK: assert property (break_active |-> capture_inhibit == 2'h3)
    else $error("captures not blocked during break");
  AST_INH_CMP: assert property (!break_active
    && channel_compare_mode == 2'h3 |-> capture_inhibit == 2'h0)
    else $error("compare channels inhibited outside break");
  AST_RD_HI_ZERO: assert property (rd_ack |-> avs_readdata[31:8] == '0)
    else $error("upper read data not zero");
  AST_STATUS_RSVD: assert property (rd_ack
    && avs_address[8:2] == TCP_IDX_STATUS |-> avs_readdata[4:3] == 2'h0)
    else $error("clear or reserved status bit read as one");
  COV_EVT: cover property (overflow_event);
endmodule : tcp_core_sva

bind tcp_core tcp_core_sva u_sva (.clock(clock), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .break_active(break_active), .count_value(count_value),
  .overflow_event(overflow_event), .capture_inhibit(capture_inhibit),
  .channel_compare_mode(channel_compare_mode));

// file: tb/test_timer_counter_prescaler_core.sv
// Self-checking bench of the timer counter core over Avalon-MM.
// Assumes the external source model on the count clock pin.
`timescale 1ns/1ps
module test_timer_counter_prescaler_core
  import tcp_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [TCP_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [TCP_DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [TCP_DATA_W-1:0] avs_readdata;
  logic avs_waitrequest, ext_count_clock, overflow_event, overflow_irq;
  logic break_active = 1'b0;
  logic break_clear_enable = 1'b0;
  logic [TCP_CNT_W-1:0] count_value;
  logic [TCP_NCHAN-1:0] capture_inhibit, channel_compare_mode, channel_buffered;
  logic src_start = 1'b0;
  logic [7:0] src_edges = 8'h00;
  logic src_busy;
  logic [7:0] d;
  logic [15:0] c;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  // ****************
  // Harness
  // ****************
  always #5 clock = ~clock;
  tcp_core dut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_count_clock(ext_count_clock),
    .break_active(break_active), .break_clear_enable(break_clear_enable),
    .count_value(count_value), .overflow_event(overflow_event),
    .overflow_irq(overflow_irq), .capture_inhibit(capture_inhibit),
    .channel_compare_mode(channel_compare_mode),
    .channel_buffered(channel_buffered));
  tcp_ext_src src (.clock(clock), .nrst(nrst), .start(src_start),
    .edges(src_edges), .ext_count_clock(ext_count_clock), .busy(src_busy));
  // Watchdog: the whole run needs well under 20000 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      fail_count++;
    end
  endtask : chk
  // Request held until waitrequest is sampled low at a rising edge;
  // read data is taken at that edge and the request dropped right after
  task bus(input logic [6:0] idx, input logic wr, input logic [7:0] wd,
    input logic [3:0] be, output logic [7:0] rd);
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= be;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task wr(input logic [6:0] idx, input logic [7:0] wd);
    logic [7:0] junk;
    bus(idx, 1'b1, wd, 4'hF, junk);
  endtask : wr
  task rd(input logic [6:0] idx, output logic [7:0] v);
    bus(idx, 1'b0, 8'h00, 4'hF, v);
  endtask : rd
  task rdcnt(output logic [15:0] v);
    rd(TCP_IDX_CNT_HI, v[15:8]);
    rd(TCP_IDX_CNT_LO, v[7:0]);
  endtask : rdcnt
  task stat(input logic [7:0] exp, input string m);
    rd(TCP_IDX_STATUS, d);
    chk(d, exp, m);
  endtask : stat
  task wait_evt;
    do @(posedge clock); while (overflow_event !== 1'b1);
    @(negedge clock);
  endtask : wait_evt
  task pulses(input logic [7:0] n);
    @(posedge clock);
    src_edges <= n;
    src_start <= 1'b1;
    @(posedge clock);
    src_start <= 1'b0;
    do @(posedge clock); while (src_busy !== 1'b0);
    repeat (8) @(posedge clock);
  endtask : pulses
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    stat(TCP_STATUS_RST, "status reset");
    rd(TCP_IDX_MOD_HI, d);
    chk(d, 8'hFF, "modulo high reset");
    repeat (20) @(posedge clock);
    rdcnt(c);
    chk(c, 16'h0000, "counter ran after reset");
    chk(capture_inhibit, 2'h3, "halted capture not inhibited");
    rd(7'h50, d);
    chk(d, 8'h00, "unmapped read");
    bus(TCP_IDX_STATUS, 1'b1, 8'h07, 4'hE, d);
    stat(8'h20, "masked write changed status");
    $display("reset test done");
  endtask : t_reset
  task t_prescale;
    logic [2:0] p;
    int e;
    for (int k = 0; k < 7; k++)
    begin
      p = k[2:0];
      wr(TCP_IDX_STATUS, {5'h06, p});
      stat({5'h04, p}, "clear kept other bits");
      rdcnt(c);
      chk(c, 16'h0000, "halt with clear not zero");
      wr(TCP_IDX_STATUS, {5'h00, p});
      repeat (128) @(posedge clock);
      wr(TCP_IDX_STATUS, {5'h04, p});
      rdcnt(c);
      e = 131 >> k;
      chk(16'(c + 2 >= e && c <= e + 2), 16'h0001, "division");
    end
    $display("prescale test done");
  endtask : t_prescale
  task t_ext;
    wr(TCP_IDX_STATUS, 8'h37);
    wr(TCP_IDX_STATUS, 8'h07);
    pulses(8'h05);
    rdcnt(c);
    chk(c, 16'h0005, "external edges");
    rd(TCP_IDX_CNT_HI, d);
    pulses(8'h03);
    rd(TCP_IDX_CNT_HI, d);
    rd(TCP_IDX_CNT_LO, d);
    chk(d, 8'h05, "low byte relatched");
    rdcnt(c);
    chk(c, 16'h0008, "external edges");
    wr(TCP_IDX_STATUS, 8'h27);
    $display("external clock test done");
  endtask : t_ext
  task t_flag;
    wr(TCP_IDX_MOD_HI, 8'h00);
    wr(TCP_IDX_MOD_LO, 8'h03);
    wr(TCP_IDX_STATUS, 8'h30);
    wr(TCP_IDX_STATUS, 8'h00);
    wait_evt();
    wr(TCP_IDX_STATUS, 8'h20);
    stat(8'hA0, "flag lost without read");
    wr(TCP_IDX_STATUS, 8'hE0);
    stat(8'hE0, "flag after write of one");
    chk(overflow_irq, 1'b1, "irq missing");
    wr(TCP_IDX_STATUS, 8'h60);
    stat(8'h60, "flag not cleared");
    chk(overflow_irq, 1'b0, "irq stuck");
    wr(TCP_IDX_STATUS, 8'h00);
    wait_evt();
    rd(TCP_IDX_STATUS, d);
    wait_evt();
    wait_evt();
    wr(TCP_IDX_STATUS, 8'h20);
    stat(8'hA0, "clear not cancelled");
    wr(TCP_IDX_STATUS, 8'h20);
    wr(TCP_IDX_MOD_HI, 8'h00);
    wr(TCP_IDX_STATUS, 8'h40);
    repeat (20) @(posedge clock);
    chk(overflow_irq, 1'b0, "irq while modulo half written");
    wr(TCP_IDX_STATUS, 8'h60);
    stat(8'h60, "flag while modulo half written");
    wr(TCP_IDX_MOD_LO, 8'h03);
    wr(TCP_IDX_STATUS, 8'h40);
    wait_evt();
    wr(TCP_IDX_STATUS, 8'h60);
    stat(8'hE0, "flag after modulo low");
    wr(TCP_IDX_STATUS, 8'h20);
    $display("flag test done");
  endtask : t_flag
  task t_break;
    logic [15:0] c2;
    wr(TCP_IDX_STATUS, 8'h00);
    wait_evt();
    wr(TCP_IDX_STATUS, 8'h20);
    rd(TCP_IDX_STATUS, d);
    break_active <= 1'b1;
    stat(8'hA0, "break read");
    wr(TCP_IDX_STATUS, 8'h20);
    stat(8'hA0, "flag cleared in protected break");
    wr(TCP_IDX_STATUS, 8'h00);
    rdcnt(c);
    repeat (20) @(posedge clock);
    rdcnt(c2);
    chk(c2, c, "counter ran in break");
    wr(TCP_IDX_STATUS, 8'h20);
    break_active <= 1'b0;
    wr(TCP_IDX_STATUS, 8'h20);
    stat(8'h20, "armed clear lost in break");
    wr(TCP_IDX_STATUS, 8'h00);
    wait_evt();
    wr(TCP_IDX_STATUS, 8'h20);
    break_active <= 1'b1;
    break_clear_enable <= 1'b1;
    rd(TCP_IDX_STATUS, d);
    wr(TCP_IDX_STATUS, 8'h20);
    break_active <= 1'b0;
    stat(8'h20, "flag not cleared in open break");
    $display("break test done");
  endtask : t_break
  task t_chan;
    wr(TCP_IDX_CHAN_CFG, 8'h0F);
    rd(TCP_IDX_CHAN_CFG, d);
    chk(d, 8'h0F, "channel config");
    chk({channel_compare_mode, channel_buffered}, 4'hF, "modes");
    wr(TCP_IDX_CHAN_CFG, 8'h0D);
    @(negedge clock);
    chk(capture_inhibit, 2'h2, "halted capture");
    wr(TCP_IDX_STATUS, 8'h00);
    @(negedge clock);
    chk(capture_inhibit, 2'h0, "running capture");
    $display("channel test done");
  endtask : t_chan
  initial
  begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_prescale();
    t_ext();
    t_flag();
    t_break();
    t_chan();
    test_done();
  end
endmodule : test_timer_counter_prescaler_core
